// File: pbseq_pkg.sv
// Overview of operation
// [RL1] supply compared against thresholds at all times
// [RL2] enable only if supply high whole filter
// [RL3] enable polarity is a build option
// [RL4] button held low until host confirms
// [RL5] host confirms before the confirm window ends
// [RL6] confirm high during power-up keeps enable on
// [RL7] confirm dropped in operation turns enable off
// [RL8] button press in operation raises interrupt
// [RL9] undervoltage raises interrupt
// [RL10] both buttons long push: reset or power off
// [RL11] extra time ends on cap trip
// [RL12] second button watched only after power-up
// [RL13] reference on after reset, off in standby
// [RL14] supply-low flag per phase, released in standby
// [RL15] button status low during press filter
// [RL16] button status low for minimum pulse, then follows
// [RL17] button status ignores presses during undervoltage
// [RL18] startup: only first press seen until window
// [RL19] interrupt lasts minimum pulse, held while pressed
// [RL20] reset pulse at start-up and on long push
// [RL21] confirm low at release drops enable, else window
// [RL22] long undervoltage turns enable off
// [RL23] intervals are parameterised counters
// [RL24] standby waits for button falling edge
//
package pbseq_pkg;
    // ----------------------------------------------------------------
    // timing, in microseconds, and derived cycle counts at 100 MHz
    // ----------------------------------------------------------------
    localparam int unsigned PBSEQ_CLOCK_MHZ = 100;
    localparam int unsigned PBSEQ_FILTER_US = 30000;
    localparam int unsigned PBSEQ_WINDOW_US = 2000000;
    localparam int unsigned PBSEQ_IRQ_MIN_US = 30000;
    localparam int unsigned PBSEQ_RESET_HOLD_US = 200000;
    localparam int unsigned PBSEQ_FILTER_CYC = PBSEQ_FILTER_US * PBSEQ_CLOCK_MHZ;
    localparam int unsigned PBSEQ_WINDOW_CYC = PBSEQ_WINDOW_US * PBSEQ_CLOCK_MHZ;
    localparam int unsigned PBSEQ_IRQ_MIN_CYC = PBSEQ_IRQ_MIN_US * PBSEQ_CLOCK_MHZ;
    localparam int unsigned PBSEQ_RESET_HOLD_CYC = PBSEQ_RESET_HOLD_US * PBSEQ_CLOCK_MHZ;
    localparam int unsigned PBSEQ_CNT_W = 32;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        PBSEQ_STANDBY = 5'b0_0001,
        PBSEQ_FILTER = 5'b0_0010,
        PBSEQ_STARTUP = 5'b0_0100,
        PBSEQ_RUN = 5'b0_1000,
        PBSEQ_LATE = 5'b1_0000
    } pbseq_state_type;
endpackage : pbseq_pkg

// File: pbseq_timer.sv
`timescale 1ns/1ns
// restartable up-counter: done is high once run has lasted length cycles
module pbseq_timer
    import pbseq_pkg::*;
#(
    parameter int unsigned WIDTH = PBSEQ_CNT_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic [WIDTH-1:0] length,
    // status
    output logic done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (!run) begin
            count <= '0;
        end else if (count != length) begin
            count <= count + 1'b1;
        end
    end

    assign done = run && (count == length);
endmodule : pbseq_timer

// File: pbseq_core.sv
`timescale 1ns/1ns
module pbseq_core
    import pbseq_pkg::*;
#(
    parameter bit EN_ACTIVE_HIGH = 1'b1,
    parameter bit LONG_PUSH_RESETS = 1'b0,
    parameter int unsigned FILTER_CYC = PBSEQ_FILTER_CYC,
    parameter int unsigned WINDOW_CYC = PBSEQ_WINDOW_CYC,
    parameter int unsigned IRQ_MIN_CYC = PBSEQ_IRQ_MIN_CYC,
    parameter int unsigned RESET_HOLD_CYC = PBSEQ_RESET_HOLD_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // buttons and host
    input wire logic power_button_n,
    input wire logic second_reset_button_n,
    input wire logic supply_hold_confirm,
    // comparator results, synchronous
    input wire logic supply_above_upper,
    input wire logic supply_above_lower,
    input wire logic long_push_cap_tripped,
    input wire logic long_push_cap_fitted,
    // outputs
    output logic supply_switch_on,
    output logic system_reset_out_n,
    output logic host_irq_n,
    output logic button_state_out_n,
    output logic supply_low_flag_n,
    output logic supply_low_flag_oe,
    output logic ref_voltage_out_en
);
    // ----------------------------------------------------------------
    // state and timers
    // ----------------------------------------------------------------
    pbseq_state_type state;
    pbseq_state_type next_state;
    logic pb_prev;
    logic sr_prev;
    logic pressed;
    logic undervolt;
    logic enable;
    logic filt_done;
    logic win_done;
    logic rst_done;
    logic irq_done;
    logic uv_done;
    logic lp_done;
    logic rst_run;
    logic irq_run;
    logic long_armed;
    logic long_run;
    logic lp_stage;
    logic [1:0] uv_stage;
    logic in_startup;

    assign pressed = !power_button_n;
    assign undervolt = !supply_above_lower; // [RL1]
    assign in_startup = (state == PBSEQ_STARTUP) || (state == PBSEQ_LATE);

    // filter restarts whenever supply dips below the upper threshold
    pbseq_timer u_filt (.clock(clock), .rstn(rstn),
        .run((state == PBSEQ_FILTER) && pressed && supply_above_upper), // [RL2] [RL23]
        .length(PBSEQ_CNT_W'(FILTER_CYC)), .done(filt_done));
    pbseq_timer u_win (.clock(clock), .rstn(rstn), .run(in_startup),
        .length(PBSEQ_CNT_W'(WINDOW_CYC)), .done(win_done)); // [RL23]
    pbseq_timer u_rst (.clock(clock), .rstn(rstn), .run(rst_run),
        .length(PBSEQ_CNT_W'(RESET_HOLD_CYC)), .done(rst_done));
    pbseq_timer u_irq (.clock(clock), .rstn(rstn), .run(irq_run),
        .length(PBSEQ_CNT_W'(IRQ_MIN_CYC)), .done(irq_done));
    // separate staged timers serve the long push and the long undervoltage
    pbseq_timer u_lp (.clock(clock), .rstn(rstn), .run(long_run && !lp_stage),
        .length(PBSEQ_CNT_W'(FILTER_CYC)), .done(lp_done));
    pbseq_timer u_uv (.clock(clock), .rstn(rstn),
        .run((state == PBSEQ_RUN) && undervolt && uv_stage == 2'd0),
        .length(PBSEQ_CNT_W'(FILTER_CYC)), .done(uv_done));

    // ----------------------------------------------------------------
    // edge memory
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pb_prev <= 1'b1;
            sr_prev <= 1'b1;
        end else begin
            pb_prev <= power_button_n;
            sr_prev <= second_reset_button_n;
        end
    end

    // ----------------------------------------------------------------
    // long push: both held, filter, then minimum pulse, then cap
    // ----------------------------------------------------------------
    logic lp_irq_done;
    logic long_push;
    logic uv_irq_done;
    logic uv_off;
    pbseq_timer u_lpi (.clock(clock), .rstn(rstn), .run(long_run && lp_stage),
        .length(PBSEQ_CNT_W'(IRQ_MIN_CYC)), .done(lp_irq_done));
    pbseq_timer u_uvi (.clock(clock), .rstn(rstn),
        .run((state == PBSEQ_RUN) && undervolt && uv_stage == 2'd1),
        .length(PBSEQ_CNT_W'(IRQ_MIN_CYC)), .done(uv_irq_done));
    // no cap fitted: recognised right when the minimum pulse expires
    assign long_push = lp_irq_done && (!long_push_cap_fitted || long_push_cap_tripped); // [RL11]
    assign uv_off = (uv_stage == 2'd2) && undervolt
        && (!long_push_cap_fitted || long_push_cap_tripped); // [RL22]

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            long_armed <= 1'b0;
            long_run <= 1'b0;
            lp_stage <= 1'b0;
        end else if (state != PBSEQ_RUN || power_button_n || second_reset_button_n) begin
            long_armed <= (state == PBSEQ_RUN) && long_armed && !second_reset_button_n;
            long_run <= 1'b0;
            lp_stage <= 1'b0;
            if (state == PBSEQ_RUN && sr_prev && !second_reset_button_n) begin
                long_armed <= 1'b1; // [RL12]
            end
        end else begin
            if (sr_prev && !second_reset_button_n) begin
                long_armed <= 1'b1; // [RL12]
            end
            long_run <= long_armed || (sr_prev && !second_reset_button_n); // [RL10]
            if (lp_done) begin
                lp_stage <= 1'b1;
            end
            if (long_push) begin
                long_run <= 1'b0;
                long_armed <= 1'b0;
            end
        end
    end

    // undervoltage stage: filter, then minimum pulse, then cap delay
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            uv_stage <= 2'd0;
        end else if (state != PBSEQ_RUN || !undervolt) begin
            uv_stage <= 2'd0;
        end else if (uv_stage == 2'd0 && uv_done) begin
            uv_stage <= 2'd1;
        end else if (uv_stage == 2'd1 && uv_irq_done) begin
            uv_stage <= 2'd2;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            PBSEQ_STANDBY: begin
                if (pb_prev && pressed) begin
                    next_state = PBSEQ_FILTER; // [RL24]
                end
            end
            PBSEQ_FILTER: begin
                if (!pressed) begin
                    next_state = PBSEQ_STANDBY;
                end else if (filt_done) begin
                    next_state = PBSEQ_STARTUP; // [RL2]
                end
            end
            PBSEQ_STARTUP: begin
                if (!pressed) begin
                    // confirm low at release drops power at once
                    next_state = supply_hold_confirm ? PBSEQ_LATE : PBSEQ_STANDBY; // [RL21] [RL6]
                end else if (win_done) begin
                    next_state = supply_hold_confirm ? PBSEQ_RUN : PBSEQ_STANDBY; // [RL21]
                end
            end
            PBSEQ_LATE: begin
                // released and confirmed: run once the window has passed
                if (!supply_hold_confirm) begin
                    next_state = PBSEQ_STANDBY; // [RL7]
                end else if (win_done) begin
                    next_state = PBSEQ_RUN; // [RL18]
                end
            end
            PBSEQ_RUN: begin
                if (!supply_hold_confirm || uv_off) begin
                    next_state = PBSEQ_STANDBY; // [RL7] [RL22]
                end else if (long_push && !LONG_PUSH_RESETS) begin
                    next_state = PBSEQ_STANDBY; // [RL10]
                end
            end
            default: next_state = PBSEQ_STANDBY;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= PBSEQ_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    assign enable = (next_state == PBSEQ_STARTUP) || (next_state == PBSEQ_LATE)
        || (next_state == PBSEQ_RUN); // [RL2]

    // ----------------------------------------------------------------
    // reset pulse and reference
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_run <= 1'b0;
        end else if (state == PBSEQ_FILTER && next_state == PBSEQ_STARTUP) begin
            rst_run <= 1'b1; // [RL20]
        end else if (state == PBSEQ_RUN && long_push && LONG_PUSH_RESETS) begin
            rst_run <= 1'b1; // [RL20] [RL10]
        end else if (rst_done || next_state == PBSEQ_STANDBY) begin
            rst_run <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_voltage_out_en <= 1'b0;
        end else if (next_state == PBSEQ_STANDBY) begin
            ref_voltage_out_en <= 1'b0; // [RL13]
        end else if (!rst_run && !system_reset_out_n) begin
            ref_voltage_out_en <= 1'b1; // [RL13] on as the reset pin releases
        end
    end

    // ----------------------------------------------------------------
    // interrupt and button status
    // ----------------------------------------------------------------
    logic press_run;
    logic press_ok;
    pbseq_timer u_prs (.clock(clock), .rstn(rstn), .run(press_run && pressed),
        .length(PBSEQ_CNT_W'(FILTER_CYC)), .done(press_ok));

    // a press in operation is qualified by the filter, unless under undervoltage
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            press_run <= 1'b0;
        end else if (state != PBSEQ_RUN || !pressed || irq_run) begin
            press_run <= 1'b0;
        end else if (pb_prev && !undervolt) begin
            press_run <= 1'b1; // [RL17]
        end
    end

    // minimum pulse starts from the first cause, released once done and cause gone
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_run <= 1'b0;
        end else if (state != PBSEQ_RUN) begin
            irq_run <= 1'b0;
        end else if (press_ok || (undervolt && !irq_run)) begin
            irq_run <= 1'b1; // [RL8] [RL9]
        end else if (irq_done && !pressed && !undervolt) begin
            irq_run <= 1'b0; // [RL19]
        end
    end

    logic press_irq;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            press_irq <= 1'b0;
        end else if (press_ok) begin
            press_irq <= 1'b1;
        end else if (!irq_run) begin
            press_irq <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            host_irq_n <= 1'b1;
            button_state_out_n <= 1'b1;
        end else begin
            host_irq_n <= !(irq_run && (state == PBSEQ_RUN)); // [RL19]
            // start-up: only the first press, held until window ends
            button_state_out_n <= !((next_state == PBSEQ_FILTER)
                || (state == PBSEQ_STARTUP && pressed) // [RL15] [RL18]
                || (press_run && pressed) || (irq_run && press_irq)); // [RL16]
        end
    end

    // ----------------------------------------------------------------
    // registered pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            supply_switch_on <= !EN_ACTIVE_HIGH;
            system_reset_out_n <= 1'b1;
            supply_low_flag_n <= 1'b1;
            supply_low_flag_oe <= 1'b0;
        end else begin
            supply_switch_on <= enable ~^ EN_ACTIVE_HIGH; // [RL3]
            system_reset_out_n <= !rst_run;
            supply_low_flag_n <= (state == PBSEQ_RUN) ? !undervolt : supply_above_upper; // [RL14]
            supply_low_flag_oe <= (next_state != PBSEQ_STANDBY); // [RL14]
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_standby_off: assert property (@(posedge clock) disable iff (!rstn) // [RL24]
        state == PBSEQ_STANDBY |=> (supply_switch_on == !EN_ACTIVE_HIGH))
        else $error("enable active in standby");
    chk_confirm_drop: assert property (@(posedge clock) disable iff (!rstn) // [RL7]
        (state == PBSEQ_RUN && !supply_hold_confirm) |=> state == PBSEQ_STANDBY)
        else $error("confirm low did not end operation");
    chk_release_unconf: assert property (@(posedge clock) disable iff (!rstn) // [RL21]
        (state == PBSEQ_STARTUP && !pressed && !supply_hold_confirm) |=> ##1
        supply_switch_on == !EN_ACTIVE_HIGH)
        else $error("release without confirm kept power");
    chk_filter_supply: assert property (@(posedge clock) disable iff (!rstn) // [RL2]
        (state == PBSEQ_FILTER && !supply_above_upper) |=> state != PBSEQ_STARTUP)
        else $error("start-up despite low supply");
    chk_irq_startup: assert property (@(posedge clock) disable iff (!rstn) // [RL19]
        in_startup |=> host_irq_n)
        else $error("interrupt during power-up");
    chk_reset_start: assert property (@(posedge clock) disable iff (!rstn) // [RL20]
        (state == PBSEQ_FILTER && next_state == PBSEQ_STARTUP) |=> ##1 !system_reset_out_n)
        else $error("no reset at start-up");
    chk_flag_float: assert property (@(posedge clock) disable iff (!rstn) // [RL14]
        state == PBSEQ_STANDBY && $past(state) == PBSEQ_STANDBY |-> !supply_low_flag_oe)
        else $error("supply flag driven in standby");
    chk_ref_standby: assert property (@(posedge clock) disable iff (!rstn) // [RL13]
        (state == PBSEQ_STANDBY && $past(state) == PBSEQ_STANDBY) |-> !ref_voltage_out_en)
        else $error("reference on in standby");
    chk_irq_uv: assert property (@(posedge clock) disable iff (!rstn) // [RL9]
        (state == PBSEQ_RUN && undervolt && supply_hold_confirm) [*2] |=> !host_irq_n)
        else $error("undervoltage gave no interrupt");
endmodule : pbseq_core

// File: pbseq_host_model.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// host processor model: confirms start-up a set time after power
// ------------------------------------------------------------
module pbseq_host_model (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // control from the bench
    input wire logic enable_on,
    input wire logic [15:0] confirm_delay,
    input wire logic drop_now,
    // to the sequencer
    output logic supply_hold_confirm
);
    logic [15:0] count;
    logic dropped;

    // an unpowered host cannot hold confirm high, so the pull-down wins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= 16'h0000;
            dropped <= 1'b0;
            supply_hold_confirm <= 1'b0;
        end else if (!enable_on) begin
            count <= 16'h0000;
            dropped <= 1'b0;
            supply_hold_confirm <= 1'b0;
        end else begin
            if (count != confirm_delay) begin
                count <= count + 16'h0001;
            end
            if (drop_now) begin
                dropped <= 1'b1;
            end
            supply_hold_confirm <= (count == confirm_delay) && !dropped && !drop_now;
        end
    end
endmodule : pbseq_host_model

// File: pushbutton_power_sequencer_tb.sv
`timescale 1ns/1ns
module pushbutton_power_sequencer_tb;
    import pbseq_pkg::*;
    localparam int F = 8;
    localparam int W = 40;
    localparam int I = 8;
    logic clock = 1'b0;
    logic rstn, power_button_n, second_reset_button_n, supply_hold_confirm;
    logic supply_above_upper, supply_above_lower, long_push_cap_tripped, long_push_cap_fitted;
    logic supply_switch_on, system_reset_out_n, host_irq_n, button_state_out_n;
    logic supply_low_flag_n, supply_low_flag_oe, ref_voltage_out_en, en_on, drop_now;
    logic [15:0] confirm_delay;
    logic sw_alt, rst_alt_n;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;

    always #5 clock = ~clock;
    assign en_on = (supply_switch_on === 1'b1);

    pbseq_core #(.EN_ACTIVE_HIGH(1'b1), .LONG_PUSH_RESETS(1'b0), .FILTER_CYC(F),
        .WINDOW_CYC(W), .IRQ_MIN_CYC(I), .RESET_HOLD_CYC(8)) uut (
        .clock(clock), .rstn(rstn), .power_button_n(power_button_n),
        .second_reset_button_n(second_reset_button_n),
        .supply_hold_confirm(supply_hold_confirm), .supply_above_upper(supply_above_upper),
        .supply_above_lower(supply_above_lower), .long_push_cap_tripped(long_push_cap_tripped),
        .long_push_cap_fitted(long_push_cap_fitted), .supply_switch_on(supply_switch_on),
        .system_reset_out_n(system_reset_out_n), .host_irq_n(host_irq_n),
        .button_state_out_n(button_state_out_n), .supply_low_flag_n(supply_low_flag_n),
        .supply_low_flag_oe(supply_low_flag_oe), .ref_voltage_out_en(ref_voltage_out_en));

    // other build options, same stimulus; its host follows the first enable
    pbseq_core #(.EN_ACTIVE_HIGH(1'b0), .LONG_PUSH_RESETS(1'b1), .FILTER_CYC(F),
        .WINDOW_CYC(W), .IRQ_MIN_CYC(I), .RESET_HOLD_CYC(8)) uut_alt (
        .clock(clock), .rstn(rstn), .power_button_n(power_button_n),
        .second_reset_button_n(second_reset_button_n),
        .supply_hold_confirm(supply_hold_confirm), .supply_above_upper(supply_above_upper),
        .supply_above_lower(supply_above_lower), .long_push_cap_tripped(long_push_cap_tripped),
        .long_push_cap_fitted(long_push_cap_fitted), .supply_switch_on(sw_alt),
        .system_reset_out_n(rst_alt_n), .host_irq_n(), .button_state_out_n(),
        .supply_low_flag_n(), .supply_low_flag_oe(), .ref_voltage_out_en());

    pbseq_host_model host (.clock(clock), .rstn(rstn), .enable_on(en_on),
        .confirm_delay(confirm_delay), .drop_now(drop_now),
        .supply_hold_confirm(supply_hold_confirm));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task give_verdict;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    task check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check

    // inputs always change one unit after the rising edge
    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task wait_en(input logic want, input int limit);
        int i;
        i = 0;
        while (en_on !== want && i < limit) begin
            step(1);
            i++;
        end
    endtask : wait_en

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task power_up;
        confirm_delay = 16'h0003;
        power_button_n = 1'b0;
        step(2);
        check(button_state_out_n === 1'b0, "status not low in filter");
        wait_en(1'b1, F + 10);
        check(en_on, "enable not on after press");
        check(sw_alt === 1'b0, "active-low enable not low");
        // the reset pin follows the enable by one cycle
        step(1);
        check(system_reset_out_n === 1'b0, "no reset at start");
        check(ref_voltage_out_en === 1'b0, "reference on during reset");
        // the button stays held until the host has confirmed
        step(5);
        power_button_n = 1'b1;
        step(3);
        power_button_n = 1'b0;
        step(3);
        check(button_state_out_n === 1'b1, "second start-up press seen");
        power_button_n = 1'b1;
        step(W - 1);
        check(en_on, "enable lost after confirm");
        check(system_reset_out_n === 1'b1, "reset not released");
        check(ref_voltage_out_en === 1'b1, "reference off after reset");
        check(supply_low_flag_oe === 1'b1 && supply_low_flag_n === 1'b1, "flag in run");
    endtask : power_up

    task t_press_irq;
        power_up();
        power_button_n = 1'b0;
        step(F + I + 4);
        check(host_irq_n === 1'b0, "no irq on held press");
        check(button_state_out_n === 1'b0, "status high while held");
        power_button_n = 1'b1;
        step(4);
        check(host_irq_n === 1'b1 && button_state_out_n === 1'b1, "no release");
        // a short press must still give a full minimum pulse
        power_button_n = 1'b0;
        step(F + 3);
        power_button_n = 1'b1;
        step(I - 4);
        check(host_irq_n === 1'b0, "irq pulse too short");
        check(button_state_out_n === 1'b0, "status pulse too short");
        step(I + 4);
        check(host_irq_n === 1'b1 && en_on, "irq stuck or power lost");
        $display("test press_irq done");
    endtask : t_press_irq

    task t_host_drop;
        drop_now = 1'b1;
        wait_en(1'b0, 5);
        check(!en_on, "enable kept after host drop");
        check(sw_alt === 1'b1, "active-low enable not released");
        drop_now = 1'b0;
        step(3);
        check(supply_low_flag_oe === 1'b0, "flag driven in standby");
        check(ref_voltage_out_en === 1'b0, "reference on in standby");
        step(20);
        check(!en_on, "left standby without press");
        $display("test host_drop done");
    endtask : t_host_drop

    task t_no_supply;
        confirm_delay = 16'h03e8;
        supply_above_upper = 1'b0;
        power_button_n = 1'b0;
        step(F + 6);
        check(!en_on, "enable with low supply");
        supply_above_upper = 1'b1;
        wait_en(1'b1, F + 10);
        check(en_on, "enable not on after supply recovered");
        step(3);
        power_button_n = 1'b1;
        wait_en(1'b0, 3);
        check(!en_on, "enable kept on release without confirm");
        step(3);
        $display("test no_supply done");
    endtask : t_no_supply

    task t_undervolt;
        power_up();
        supply_above_lower = 1'b0;
        step(3);
        check(host_irq_n === 1'b0, "no irq on undervoltage");
        check(supply_low_flag_n === 1'b0, "flag high in undervoltage");
        power_button_n = 1'b0;
        step(F + 2);
        check(button_state_out_n === 1'b1, "status reacted in undervoltage");
        power_button_n = 1'b1;
        wait_en(1'b0, F + I + 30);
        check(!en_on, "enable kept in long undervoltage");
        supply_above_lower = 1'b1;
        step(3);
        $display("test undervolt done");
    endtask : t_undervolt

    task t_long_push;
        // no capacitor first: recognised as the minimum pulse ends
        power_up();
        power_button_n = 1'b0;
        second_reset_button_n = 1'b0;
        step(F + I);
        check(en_on, "long push too early");
        wait_en(1'b0, 6);
        check(!en_on, "no long push without capacitor");
        step(1);
        check(rst_alt_n === 1'b0 && sw_alt === 1'b0, "no reset pulse");
        power_button_n = 1'b1;
        second_reset_button_n = 1'b1;
        step(3);
        long_push_cap_fitted = 1'b1;
        power_up();
        power_button_n = 1'b0;
        second_reset_button_n = 1'b0;
        step(F + I + 10);
        check(en_on, "long push before capacitor trip");
        long_push_cap_tripped = 1'b1;
        wait_en(1'b0, 10);
        check(!en_on, "long push did not power off");
        power_button_n = 1'b1;
        second_reset_button_n = 1'b1;
        long_push_cap_tripped = 1'b0;
        step(3);
        $display("test long_push done");
    endtask : t_long_push

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        power_button_n = 1'b1;
        second_reset_button_n = 1'b1;
        supply_above_upper = 1'b1;
        supply_above_lower = 1'b1;
        long_push_cap_tripped = 1'b0;
        long_push_cap_fitted = 1'b0;
        drop_now = 1'b0;
        confirm_delay = 16'h0003;
        step(5);
        check(!en_on && system_reset_out_n === 1'b1 && host_irq_n === 1'b1, "reset outputs");
        check(supply_low_flag_oe === 1'b0 && ref_voltage_out_en === 1'b0, "reset flag or ref");
        check(sw_alt === 1'b1 && rst_alt_n === 1'b1, "reset outputs, other options");
        rstn = 1'b1;
        step(2);
        t_press_irq();
        t_host_drop();
        t_no_supply();
        t_undervolt();
        t_long_push();
        give_verdict();
    end
endmodule : pushbutton_power_sequencer_tb
